// File: core/tz_timer.sv
// Purpose: general-purpose counter with prescaler, period compare or 16-bit rollover, postscaler
// Assumes: APB slave with zero wait states; tick input synchronous to I_CLK, pin resynchronised here
// Notes:   output level goes to other peripherals and to the pin select outside this block
`include "tz_timer_defs.svh"

module tz_timer (
    input  wire logic                        I_CLK,
    input  wire logic                        I_RST_B,
    input  wire tz_timer_pkg::tz_apb_req_type I_APB,
    input  wire logic                        I_EXT_CLK,
    input  wire logic                        I_SLOW_TICK,
    input  wire logic                        I_SLEEP,
    output tz_timer_pkg::tz_apb_rsp_type     O_APB,
    output logic                             O_OUT,
    output logic                             O_IRQ,
    output logic                             O_WAKE
);
    tz_timer_pkg::tz_state_type q;
    tz_timer_pkg::tz_state_type d;

    logic        setup;
    logic        wr;
    logic        rd_setup;
    logic        wr_c0;
    logic        wr_c1;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_st;
    logic        wr_en;
    logic        src_tick;
    logic        running;
    logic        pre_clr;
    logic        pre_en;
    logic [15:0] pre_term;
    logic        pre_tick;
    logic        cnt_tick;
    logic        evt;
    logic        post_clr;
    logic [15:0] post_term;
    logic        post_tick;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    // ==========================================================
    // bus decode
    assign setup    = I_APB.psel && !I_APB.penable;
    assign rd_setup = setup && !I_APB.pwrite;
    assign wr       = I_APB.psel && I_APB.penable && q.apb.pready && I_APB.pwrite;
    assign wr_c0    = wr && (I_APB.paddr == `TZ_OFF_CTRL0);
    assign wr_c1    = wr && (I_APB.paddr == `TZ_OFF_CTRL1);
    assign wr_lo    = wr && (I_APB.paddr == `TZ_OFF_CNT_LO);
    assign wr_hi    = wr && (I_APB.paddr == `TZ_OFF_CNT_HI);
    assign wr_st    = wr && (I_APB.paddr == `TZ_OFF_IRQ_STAT);
    assign wr_en    = wr && (I_APB.paddr == `TZ_OFF_IRQ_EN);

    // ==========================================================
    // read mux
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        unique case (I_APB.paddr)
            `TZ_OFF_CTRL0: begin
                rd_byte = {q.ctrl0.enable, 1'b0, q.out_lvl, q.ctrl0.mode16, q.ctrl0.postscale_ratio_select};
            end
            `TZ_OFF_CTRL1: begin
                rd_byte = q.ctrl1;
            end
            `TZ_OFF_CNT_LO: begin
                rd_byte = q.cnt_lo;
            end
            `TZ_OFF_CNT_HI: begin
                rd_byte = q.ctrl0.mode16 ? q.hi_rd_buf : q.cnt_hi;
            end
            `TZ_OFF_IRQ_STAT: begin
                rd_byte = {7'h00, q.flag};
            end
            `TZ_OFF_IRQ_EN: begin
                rd_byte = {7'h00, q.irq_en};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // count clock source
    always_comb begin
        unique case (q.ctrl1.count_clock_select)
            // pin edges into the prescaler, only the second sync stage onward is looked at
            `TZ_CS_PIN_RISE:  src_tick = q.pin_sync[1] && !q.pin_sync[2];
            `TZ_CS_PIN_FALL:  src_tick = !q.pin_sync[1] && q.pin_sync[2];
            `TZ_CS_SYSCLK:    src_tick = 1'b1;
            `TZ_CS_SLOW_TICK: src_tick = I_SLOW_TICK;
            // unused codes leave the counter stopped rather than guessing a source
            default:          src_tick = 1'b0;
        endcase
    end

    // sync mode stops in sleep; async keeps going if its source still runs
    assign running  = q.ctrl0.enable
                      && !(I_SLEEP && (!q.ctrl1.async_mode || q.ctrl1.count_clock_select == `TZ_CS_SYSCLK));

    // prescaler cleared by low byte or ctrl1 writes
    assign pre_clr  = wr_lo || wr_c1;
    assign pre_en   = src_tick && running;
    assign pre_term = (16'h0001 << q.ctrl1.prescale_ratio_select) - 16'h0001;

    tz_scaler #(
        .W (16)
    ) u_prescaler (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_clr   (pre_clr),
        .i_en    (pre_en),
        .i_term  (pre_term),
        .o_tick  (pre_tick)
    );

    // resync stage unless asynchronous; trades one cycle of latency for a clean edge
    assign cnt_tick = running && !wr_lo && (q.ctrl1.async_mode ? pre_tick : q.pre_tick_dly);

    always_comb begin
        if (q.ctrl0.mode16) begin
            evt = cnt_tick && ({q.cnt_hi, q.cnt_lo} == 16'hffff);
        end else begin
            evt = cnt_tick && (q.cnt_lo == q.cnt_hi);
        end
    end

    // postscaler cleared by low byte or ctrl0 writes
    assign post_clr  = wr_lo || wr_c0;
    assign post_term = {12'h000, q.ctrl0.postscale_ratio_select};

    // post_tick is the postscaled event pulse
    tz_scaler #(
        .W (16)
    ) u_postscaler (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_clr   (post_clr),
        .i_en    (evt),
        .i_term  (post_term),
        .o_tick  (post_tick)
    );

    // ==========================================================
    // next state
    always_comb begin
        d              = q;
        d.pin_sync     = {q.pin_sync[1:0], I_EXT_CLK};
        d.pre_tick_dly = pre_tick && running;
        d.apb.pready   = 1'b0;
        d.apb.pslverr  = 1'b0;
        if (setup) begin
            d.apb.pready  = 1'b1;
            d.apb.pslverr = !rd_hit;
            d.apb.prdata  = I_APB.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            // reading the low byte freezes the high byte for a coherent 16-bit read
            if (rd_setup && I_APB.paddr == `TZ_OFF_CNT_LO) begin
                d.hi_rd_buf = q.cnt_hi;
            end
        end

        // counting
        if (cnt_tick) begin
            if (q.ctrl0.mode16) begin
                {d.cnt_hi, d.cnt_lo} = {q.cnt_hi, q.cnt_lo} + 16'h0001;
            end else if (evt) begin
                d.cnt_lo = 8'h00;
            end else begin
                d.cnt_lo = q.cnt_lo + 8'h01;
            end
        end

        // register writes win over counting
        if (wr_c0) begin
            d.ctrl0.enable                 = I_APB.pwdata[`TZ_C0_ENABLE_BIT];
            d.ctrl0.mode16                 = I_APB.pwdata[`TZ_C0_MODE16_BIT];
            d.ctrl0.postscale_ratio_select = I_APB.pwdata[`TZ_C0_POST_LSB +: 4];
        end
        if (wr_c1) begin
            d.ctrl1.count_clock_select    = I_APB.pwdata[`TZ_C1_CS_LSB +: 3];
            d.ctrl1.async_mode            = I_APB.pwdata[`TZ_C1_ASYNC_BIT];
            d.ctrl1.prescale_ratio_select = I_APB.pwdata[`TZ_C1_PRE_LSB +: 4];
        end
        if (wr_hi) begin
            if (q.ctrl0.mode16) begin
                d.hi_wr_buf = I_APB.pwdata[7:0];
            end else begin
                d.cnt_hi = I_APB.pwdata[7:0];
            end
        end
        if (wr_lo) begin
            d.cnt_lo = I_APB.pwdata[7:0];
            if (q.ctrl0.mode16) begin
                d.cnt_hi = q.hi_wr_buf;
            end
        end
        if (wr_en) begin
            d.irq_en = I_APB.pwdata[`TZ_IRQ_EVENT_BIT];
        end

        // flag per postscaled event; a new event beats a write-one clear
        d.flag = post_tick || (q.flag && !(wr_st && I_APB.pwdata[`TZ_IRQ_EVENT_BIT]));
        d.out_lvl = q.out_lvl ^ post_tick;
        d.irq  = d.flag && d.irq_en;
        d.wake = d.irq && I_SLEEP;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            q        <= '0;
            q.ctrl0  <= `TZ_RST_CTRL0;
            q.ctrl1  <= `TZ_RST_CTRL1;
            q.cnt_lo <= `TZ_RST_CNT;
            q.cnt_hi <= `TZ_RST_PERIOD;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign O_APB  = q.apb;
    // level for peripherals and pin routing
    assign O_OUT  = q.out_lvl;
    assign O_IRQ  = q.irq;
    assign O_WAKE = q.wake;

    // ==========================================================
    // checks
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    sleep_halt_a: assert property (
        (I_SLEEP && !q.ctrl1.async_mode) |-> !cnt_tick)
        else $error("counter advanced in synchronous sleep");

    match_clear_a: assert property (
        (evt && !q.ctrl0.mode16) |=> (q.cnt_lo == 8'h00))
        else $error("period match did not restart the low byte");

    roll_over_a: assert property (
        (cnt_tick && q.ctrl0.mode16 && {q.cnt_hi, q.cnt_lo} == 16'hffff)
        |-> evt ##1 ({q.cnt_hi, q.cnt_lo} == 16'h0000))
        else $error("sixteen-bit rollover missed");

    post_unit_a: assert property (
        (evt && q.ctrl0.postscale_ratio_select == 4'h0 && !post_clr) |-> post_tick)
        else $error("1:1 postscale did not pass every event");

    flag_set_a: assert property (
        post_tick |=> q.flag ##1 (q.irq == (q.flag && q.irq_en)))
        else $error("event flag or interrupt not raised");

    out_toggle_a: assert property (
        post_tick |=> (O_OUT != $past(O_OUT)))
        else $error("output did not toggle on postscaled pulse");

    out_steady_a: assert property (
        !post_tick |=> (O_OUT == $past(O_OUT)))
        else $error("output moved without a postscaled pulse");

    status_read_a: assert property (
        (rd_setup && I_APB.paddr == `TZ_OFF_CTRL0) |=> (O_APB.prdata[`TZ_C0_OUT_BIT] == $past(q.out_lvl)))
        else $error("output status bit does not track output");

    resync_delay_a: assert property (
        (pre_tick && running && !q.ctrl1.async_mode) ##1 (running && !wr_lo) |-> cnt_tick)
        else $error("synchronised prescaled tick lost");

    async_sleep_a: assert property (
        (I_SLEEP && q.ctrl1.async_mode && q.ctrl0.enable && pre_tick && !wr_lo) |-> cnt_tick)
        else $error("asynchronous mode stopped in sleep");

    apb_answer_a: assert property (
        setup |=> O_APB.pready ##1 !O_APB.pready)
        else $error("bus answer not one cycle after setup");

    // a dropped or doubled count tick shows up as a step other than one
    wide_step_a: assert property (
        (cnt_tick && q.ctrl0.mode16) |=> ({q.cnt_hi, q.cnt_lo} == $past({q.cnt_hi, q.cnt_lo}) + 16'h0001))
        else $error("sixteen-bit count did not step by one");

    narrow_step_a: assert property (
        (cnt_tick && !q.ctrl0.mode16 && !evt) |=> (q.cnt_lo == $past(q.cnt_lo) + 8'h01))
        else $error("eight-bit count did not step by one");

    // a cleared scaler restarts from zero, so only a 1:1 ratio may tick at once
    pre_clear_a: assert property (
        pre_clr |=> (!pre_tick || q.ctrl1.prescale_ratio_select == 4'h0))
        else $error("prescaler ticked right after being cleared");

    post_clear_a: assert property (
        post_clr |=> (!post_tick || q.ctrl0.postscale_ratio_select == 4'h0))
        else $error("postscaler ticked right after being cleared");

    // wake is the interrupt gated by sleep, registered in the same cycle as the interrupt
    wake_level_a: assert property (
        O_WAKE == ($past(I_SLEEP) && O_IRQ))
        else $error("wake does not follow the interrupt in sleep");

    // scenario coverage
    match_cover_c: cover property (evt && !q.ctrl0.mode16);
    roll_cover_c: cover property (evt && q.ctrl0.mode16);
    irq_cover_c: cover property (post_tick ##1 O_IRQ);
    wake_cover_c: cover property (O_WAKE);
    async_cover_c: cover property (I_SLEEP && q.ctrl1.async_mode && cnt_tick);

endmodule

// File: core/tz_timer_defs.svh
// Purpose: register offsets, field positions, reset values and clock-source codes of the timer
// Assumes: 12-bit APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef TZ_TIMER_DEFS_SVH
`define TZ_TIMER_DEFS_SVH

// ==========================================================
// register offsets
`define TZ_OFF_CTRL0      12'h000
`define TZ_OFF_CTRL1      12'h004
`define TZ_OFF_CNT_LO     12'h008
`define TZ_OFF_CNT_HI     12'h00c
`define TZ_OFF_IRQ_STAT   12'h010
`define TZ_OFF_IRQ_EN     12'h014

// ==========================================================
// field positions
`define TZ_C0_ENABLE_BIT  7
`define TZ_C0_OUT_BIT     5
`define TZ_C0_MODE16_BIT  4
`define TZ_C0_POST_LSB    0
`define TZ_C1_CS_LSB      5
`define TZ_C1_ASYNC_BIT   4
`define TZ_C1_PRE_LSB     0
`define TZ_IRQ_EVENT_BIT  0

// ==========================================================
// reset values
`define TZ_RST_CTRL0      6'h00
`define TZ_RST_CTRL1      8'h00
`define TZ_RST_CNT        8'h00
`define TZ_RST_PERIOD     8'hff

// ==========================================================
// count clock sources
`define TZ_CS_PIN_RISE    3'h0
`define TZ_CS_PIN_FALL    3'h1
`define TZ_CS_SYSCLK      3'h2
`define TZ_CS_SLOW_TICK   3'h3

`endif

// File: core/tz_timer_pkg.sv
// Purpose: types shared by the timer files
// Assumes: APB3 style slave, no byte strobes
// Notes:   constants live in tz_timer_defs.svh
package tz_timer_pkg;

    // ==========================================================
    // bus carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tz_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tz_apb_rsp_type;

    // ==========================================================
    // control registers
    typedef struct packed {
        logic       enable;
        logic       mode16;
        logic [3:0] postscale_ratio_select;
    } tz_ctrl0_type;

    typedef struct packed {
        logic [2:0] count_clock_select;
        logic       async_mode;
        logic [3:0] prescale_ratio_select;
    } tz_ctrl1_type;

    // ==========================================================
    // whole timer state
    typedef struct packed {
        tz_ctrl0_type   ctrl0;
        tz_ctrl1_type   ctrl1;
        logic [7:0]     cnt_lo;
        logic [7:0]     cnt_hi;
        logic [7:0]     hi_rd_buf;
        logic [7:0]     hi_wr_buf;
        logic           flag;
        logic           irq_en;
        logic           out_lvl;
        logic [2:0]     pin_sync;
        logic           pre_tick_dly;
        logic           irq;
        logic           wake;
        tz_apb_rsp_type apb;
    } tz_state_type;

    typedef struct packed {
        logic [15:0] cnt;
    } tz_scaler_state_type;

endpackage

// File: core/tz_scaler.sv
// Purpose: divide an enable stream, one tick every (terminal + 1) input enables
// Assumes: terminal only changes together with a clear
// Notes:   count is hidden from software; used as prescaler and postscaler
module tz_scaler #(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_clr,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_term,
    output logic              o_tick
);
    tz_timer_pkg::tz_scaler_state_type q;
    tz_timer_pkg::tz_scaler_state_type d;

    // ==========================================================
    // next state
    always_comb begin
        d      = q;
        o_tick = 1'b0;
        if (i_clr) begin
            d.cnt = '0;
        end else if (i_en) begin
            // >= guards against a terminal lowered below the running count
            if (q.cnt[W-1:0] >= i_term) begin
                o_tick = 1'b1;
                d.cnt  = '0;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // checks
    scaler_clear_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b) i_clr |=> (q.cnt == 16'h0000))
        else $error("scaler count not cleared by a register write");

endmodule

// File: testbench/tz_pin_model.sv
// Purpose: external count clock pin as seen by the timer
// Assumes: caller starts a burst just after a rising clock edge
// Notes:   pin rests low between bursts, no free-running clock
module tz_pin_model (
    input  wire logic i_clk,
    output logic      o_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_pin = 1'b0;

    // ==========================================================
    // burst of full pulses
    // rising then falling edges
    task automatic send(input int n, input int half);
        repeat (n) begin
            o_pin <= 1'b1;
            repeat (half) @(posedge i_clk);
            o_pin <= 1'b0;
            repeat (half) @(posedge i_clk);
        end
    endtask
endmodule

// File: testbench/tz_timer_tb_top.sv
// Purpose: self-checking bench for the timer
// Assumes: zero-wait APB slave, output level not touched by control writes
// Notes:   toggle gaps are measured edge to edge, so sync offsets cancel
`include "tz_timer_defs.svh"
module tz_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0]  pre;
        logic [3:0]  post;
        logic [7:0]  per;
        logic [31:0] gap;
    } tz_row_type;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic        err;
    } tz_rd_type;

    logic                         clk;
    logic                         rst_b;
    tz_timer_pkg::tz_apb_req_type apb_req;
    tz_timer_pkg::tz_apb_rsp_type apb_rsp;
    logic                         ext_clk;
    logic                         slow_tick;
    logic                         sleep_req;
    logic                         tmr_out;
    logic                         irq;
    logic                         wake;
    logic                         lvl;
    logic [31:0]                  q;
    logic                         e;
    int                           n;
    int                           error_cnt;
    int                           total_checks;

    // gaps kept at 8 or more so a disable write lands before the next toggle
    tz_row_type rows [5] = '{'{4'h0, 4'h0, 8'h07, 32'h8}, '{4'h0, 4'h1, 8'h03, 32'h8},
        '{4'h2, 4'h0, 8'h01, 32'h8}, '{4'h0, 4'hf, 8'h00, 32'h10}, '{4'h1, 4'h2, 8'h02, 32'h12}};
    tz_rd_type regs [8] = '{'{`TZ_OFF_CTRL0, 32'h0, 1'b0}, '{`TZ_OFF_CTRL1, 32'h0, 1'b0},
        '{`TZ_OFF_CNT_LO, 32'h0, 1'b0}, '{`TZ_OFF_CNT_HI, 32'hff, 1'b0}, '{`TZ_OFF_IRQ_STAT, 32'h0, 1'b0},
        '{`TZ_OFF_IRQ_EN, 32'h0, 1'b0}, '{12'h018, 32'h0, 1'b1}, '{12'h002, 32'h0, 1'b1}};

    always #5 clk = ~clk;

    tz_timer u_tz_timer (.I_CLK(clk), .I_RST_B(rst_b), .I_APB(apb_req), .I_EXT_CLK(ext_clk),
        .I_SLOW_TICK(slow_tick), .I_SLEEP(sleep_req), .O_APB(apb_rsp), .O_OUT(tmr_out), .O_IRQ(irq),
        .O_WAKE(wake));
    tz_pin_model u_tz_pin_model (.i_clk(clk), .o_pin(ext_clk));

    // ==========================================================
    // helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        chk("pready", 32'(apb_rsp.pready), 32'h1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // waits for the next output change and counts edges on the way
    task automatic wt(input int lim);
        logic o;
        o = tmr_out;
        n = 0;
        while (tmr_out === o && n < lim) begin
            @(posedge clk);
            n++;
        end
        lvl = ~lvl;
    endtask

    task automatic pins_wait(input int cnt);
        u_tz_pin_model.send(cnt, 3);
        repeat (8) @(posedge clk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        apb_req = '0;
        slow_tick = 1'b0;
        sleep_req = 1'b0;
        lvl = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("outputs_reset", {29'h0, tmr_out, irq, wake}, 32'h0);
        foreach (regs[i]) begin
            rd(regs[i].a);
            chk("reset_value", q, regs[i].d);
            chk("slverr", 32'(e), 32'(regs[i].err));
        end
        wr(`TZ_OFF_IRQ_EN, 32'h1);
        foreach (rows[i]) begin
            wr(`TZ_OFF_CTRL0, 32'h0);
            wr(`TZ_OFF_CNT_HI, {24'h0, rows[i].per});
            wr(`TZ_OFF_CTRL1, {24'h0, 4'h4, rows[i].pre});
            wr(`TZ_OFF_CNT_LO, 32'h0);
            wr(`TZ_OFF_IRQ_STAT, 32'h1);
            wr(`TZ_OFF_CTRL0, {24'h0, 4'h8, rows[i].post});
            wt(70000);
            wt(70000);
            chk("toggle_gap", 32'(n), rows[i].gap);
            chk("irq_level", 32'(irq), 32'h1);
            wr(`TZ_OFF_CTRL0, 32'h0);
            rd(`TZ_OFF_CTRL0);
            chk("out_status", 32'(q[5]), 32'(lvl));
            chk("out_level", 32'(tmr_out), 32'(lvl));
            rd(`TZ_OFF_IRQ_STAT);
            chk("flag_set", q, 32'h1);
            wr(`TZ_OFF_IRQ_STAT, 32'h1);
            rd(`TZ_OFF_IRQ_STAT);
            chk("flag_clear", q, 32'h0);
            chk("irq_clear", 32'(irq), 32'h0);
        end
        wr(`TZ_OFF_IRQ_EN, 32'h0);
        wr(`TZ_OFF_CTRL0, 32'h80);
        wt(100);
        chk("irq_masked", 32'(irq), 32'h0);
        wr(`TZ_OFF_CTRL0, 32'h0);
        rd(`TZ_OFF_IRQ_STAT);
        chk("flag_masked", q, 32'h1);
        wr(`TZ_OFF_IRQ_STAT, 32'h1);
        wr(`TZ_OFF_CTRL0, 32'h10);
        wr(`TZ_OFF_CNT_HI, 32'h12);
        wr(`TZ_OFF_CNT_LO, 32'h34);
        rd(`TZ_OFF_CNT_LO);
        chk("wide_low", q, 32'h34);
        rd(`TZ_OFF_CNT_HI);
        chk("wide_high", q, 32'h12);
        wr(`TZ_OFF_CNT_HI, 32'hff);
        wr(`TZ_OFF_CNT_LO, 32'hf0);
        wr(`TZ_OFF_CTRL1, 32'h40);
        wr(`TZ_OFF_CTRL0, 32'h90);
        wt(70000);
        wt(70000);
        chk("wide_gap", 32'(n), 32'h10000);
        wr(`TZ_OFF_CTRL0, 32'h0);
        wr(`TZ_OFF_CNT_HI, 32'h3);
        // every source code except the free-running one gets four stimuli
        for (int cs = 0; cs < 8; cs++) begin
            if (cs != 2) begin
                wr(`TZ_OFF_CTRL0, 32'h0);
                wr(`TZ_OFF_CTRL1, {24'h0, 3'(cs), 5'h00});
                wr(`TZ_OFF_CNT_LO, 32'h0);
                wr(`TZ_OFF_CTRL0, 32'h80);
                fork
                    pins_wait(4);
                    repeat (4) begin
                        slow_tick <= 1'b1;
                        @(posedge clk);
                        slow_tick <= 1'b0;
                        repeat (5) @(posedge clk);
                    end
                join
                lvl = lvl ^ (cs < 4);
                chk("source_count", 32'(tmr_out), 32'(lvl));
            end
        end
        sleep_req <= 1'b1;
        wr(`TZ_OFF_CTRL0, 32'h0);
        wr(`TZ_OFF_CTRL1, 32'h0);
        wr(`TZ_OFF_CNT_HI, 32'h0);
        wr(`TZ_OFF_CNT_LO, 32'h0);
        wr(`TZ_OFF_CTRL0, 32'h80);
        pins_wait(4);
        chk("sync_sleep", 32'(tmr_out), 32'(lvl));
        wr(`TZ_OFF_CTRL0, 32'h0);
        wr(`TZ_OFF_CTRL1, 32'h10);
        wr(`TZ_OFF_CNT_HI, 32'h3);
        wr(`TZ_OFF_CNT_LO, 32'h0);
        // the flag still holds events of earlier scenarios, so clear it before enabling the interrupt
        wr(`TZ_OFF_IRQ_STAT, 32'h1);
        wr(`TZ_OFF_IRQ_EN, 32'h1);
        wr(`TZ_OFF_CTRL0, 32'h80);
        pins_wait(3);
        chk("async_three", 32'(tmr_out), 32'(lvl));
        chk("no_wake", 32'(wake), 32'h0);
        pins_wait(1);
        lvl = ~lvl;
        chk("async_four", 32'(tmr_out), 32'(lvl));
        chk("wake", 32'(wake), 32'h1);
        sleep_req <= 1'b0;
        // reset in mid-run with an interrupt pending
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("rerun_outputs", {29'h0, tmr_out, irq, wake}, 32'h0);
        rd(`TZ_OFF_CNT_HI);
        chk("rerun_period", q, 32'hff);
        rd(`TZ_OFF_IRQ_STAT);
        chk("rerun_flag", q, 32'h0);
        stop_test();
    end

    // ==========================================================
    // watchdog, run needs about 66400 cycles
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule
